// File: bgd_pkg.sv
// shared constants for the bar-graph display driver
package bgd_pkg;
  localparam int SEG_N = 20;
  localparam int PWR_W = 10;
  localparam int FREQ_W = 17;
  // power in tenths of a percent of rated output, 0..1000
  localparam logic [PWR_W-1:0] PWR_STEP = 10'h032;
  localparam logic [PWR_W-1:0] PWR_FULL = 10'h3E8;
  // nominal frequency variants
  typedef enum logic [1:0] {BGD_NOM_20K = 2'h0, BGD_NOM_30K = 2'h1, BGD_NOM_40K = 2'h3} bgd_nom_t;
  // segment widths in Hz
  localparam logic [FREQ_W-1:0] SEGW_20K = 17'h00032;
  localparam logic [FREQ_W-1:0] SEGW_30K = 17'h0004C;
  localparam logic [FREQ_W-1:0] SEGW_40K = 17'h00064;
  // lower edge of the eleventh segment (index 10): 19975 Hz for 20 kHz
  localparam logic [FREQ_W-1:0] SEG10_LO_20K = 17'h04E07;
  localparam logic [FREQ_W-1:0] SEG10_LO_30K = 17'h07508;
  localparam logic [FREQ_W-1:0] SEG10_LO_40K = 17'h09C0E;
  localparam int MID_SEG = 9;
  // display source after a cycle
  localparam logic POST_POWER = 1'b0;
  localparam logic POST_FREQ = 1'b1;
  // blink half period: 250 ms at 10 MHz
  localparam int CLK_HZ = 10_000_000;
  localparam int BLINK_MS = 250;
  localparam int BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
  typedef enum logic [1:0] {BGD_IDLE = 2'b00, BGD_LIVE = 2'b01, BGD_HOLD = 2'b11} bgd_state_t;
endpackage : bgd_pkg

// File: bgd_blink.sv
// free-running blink toggle for the alarm segment
`timescale 1ns/100ps
module bgd_blink #(
  parameter int HALF_CYC = bgd_pkg::BLINK_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  output logic phase
);
  // elaboration check: the divider needs at least one clock per phase
  if (HALF_CYC < 1) begin : g_bad_half
    $error("blink half period must be at least one cycle");
  end
  logic [31:0] cnt_r;
  wire wrap = (cnt_r == 32'(HALF_CYC - 1));
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 32'h0;
      phase <= 1'b0;
    end else if (wrap) begin
      cnt_r <= 32'h0;
      phase <= ~phase;
    end else begin
      cnt_r <= cnt_r + 32'h1;
    end
  end
endmodule : bgd_blink

// File: bgd_driver.sv
// bar-graph display driver: live power, post-cycle peak or frequency, alarm blink
`timescale 1ns/100ps
// Behaviour
// - while sonics run the bar shows present power as a fraction of rated output.
// - after a cycle, by default the bar holds that cycle's peak power.
// - in frequency mode exactly one segment is lit after a cycle, placed by stored frequency.
// - the power symbol is lit whenever sonics run, even with no segment lit.
// - segment n lights once power reaches n times 5 percent, none below 5 percent.
// - test overload or external memory reset shows the middle segment blinking.
// - frequency segment width is 50, 76 or 100 Hz for 20, 30 or 40 kHz units.
// - for 20 kHz the eleventh segment covers 19975 to 20024 Hz, neighbours step by width.
// - a select input chooses post-cycle display, 0 peak power and 1 frequency, power default.
module bgd_driver #(
  parameter int BLINK_HALF = bgd_pkg::BLINK_CYC
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic SONICS_ON,
  input wire logic [bgd_pkg::PWR_W-1:0] POWER,
  input wire logic CYCLE_DONE,
  input wire logic [bgd_pkg::FREQ_W-1:0] FREQ_STORED,
  input wire logic [1:0] NOMINAL,
  input wire logic POST_SEL,
  input wire logic OVERLOAD,
  input wire logic MEM_RESET,
  input wire logic ALARM_CLEAR,
  output logic [bgd_pkg::SEG_N-1:0] SEGMENTS,
  output logic POWER_SYMBOL
);
  // elaboration checks: refuse settings the logic cannot serve
  // the blink divider needs at least one clock per phase
  if (BLINK_HALF < 1) begin : g_bad_blink
    $error("blink half period must be positive");
  end
  // indices are five bits wide and the thermometer is built in 21 bits
  if (bgd_pkg::SEG_N > 20) begin : g_bad_bar
    $error("bar length exceeds the index logic");
  end
  // the alarm segment must lie on the bar
  if (bgd_pkg::MID_SEG >= bgd_pkg::SEG_N) begin : g_bad_mid
    $error("middle segment lies off the bar");
  end
  // a zero step would leave the power step division undefined
  if (bgd_pkg::PWR_STEP == '0) begin : g_bad_step
    $error("power step must be non-zero");
  end

  // count of full 5 percent steps, saturated at the bar length
  function automatic logic [4:0] pwr_steps(input logic [bgd_pkg::PWR_W-1:0] p);
    logic [bgd_pkg::PWR_W-1:0] q;
    q = (p > bgd_pkg::PWR_FULL) ? bgd_pkg::PWR_FULL : p;
    return 5'(q / bgd_pkg::PWR_STEP);
  endfunction : pwr_steps

  // thermometer code: the lowest n segments lit
  function automatic logic [bgd_pkg::SEG_N-1:0] bar_of(input logic [4:0] n);
    logic [bgd_pkg::SEG_N:0] t;
    t = (21'h1 << n) - 21'h1;
    return t[bgd_pkg::SEG_N-1:0];
  endfunction : bar_of

  bgd_pkg::bgd_state_t state_r, state_nxt;
  logic [bgd_pkg::PWR_W-1:0] peak_r, peak_nxt;
  logic [bgd_pkg::FREQ_W-1:0] freq_r;
  logic [4:0] fseg_r;
  logic alarm_r, alarm_nxt;
  logic blink;
  logic [bgd_pkg::SEG_N-1:0] seg_nxt;

  bgd_blink #(.HALF_CYC(BLINK_HALF)) u_blink (
    .clk(CLK),
    .nrst(NRST),
    .phase(blink)
  );

  // segment width per nominal variant; the unused code is served as 20 kHz
  function automatic logic [bgd_pkg::FREQ_W-1:0] seg_width_of(input logic [1:0] n);
    logic [bgd_pkg::FREQ_W-1:0] w;
    unique case (n)
      bgd_pkg::BGD_NOM_30K: w = bgd_pkg::SEGW_30K;
      bgd_pkg::BGD_NOM_40K: w = bgd_pkg::SEGW_40K;
      default: w = bgd_pkg::SEGW_20K;
    endcase
    return w;
  endfunction : seg_width_of

  // lower edge of the eleventh segment per nominal variant
  function automatic logic [bgd_pkg::FREQ_W-1:0] seg10_lo_of(input logic [1:0] n);
    logic [bgd_pkg::FREQ_W-1:0] lo;
    unique case (n)
      bgd_pkg::BGD_NOM_30K: lo = bgd_pkg::SEG10_LO_30K;
      bgd_pkg::BGD_NOM_40K: lo = bgd_pkg::SEG10_LO_40K;
      default: lo = bgd_pkg::SEG10_LO_20K;
    endcase
    return lo;
  endfunction : seg10_lo_of

  // segment index of a frequency; segment zero starts ten widths below
  // the eleventh, and anything beyond the span is held on the nearest end
  function automatic logic [4:0] freq_index(
    input logic [bgd_pkg::FREQ_W-1:0] f,
    input logic [bgd_pkg::FREQ_W-1:0] w,
    input logic [bgd_pkg::FREQ_W-1:0] lo
  );
    logic [bgd_pkg::FREQ_W+3:0] span;
    logic [bgd_pkg::FREQ_W-1:0] base;
    logic [bgd_pkg::FREQ_W-1:0] q;
    span = 21'(w) * 21'd10;
    base = lo - span[bgd_pkg::FREQ_W-1:0];
    if (f < base) begin
      q = '0;
    end else begin
      q = (f - base) / w;
    end
    if (q > 17'(bgd_pkg::SEG_N - 1)) begin
      return 5'(bgd_pkg::SEG_N - 1);
    end
    return q[4:0];
  endfunction : freq_index

  wire [bgd_pkg::FREQ_W-1:0] seg_w = seg_width_of(NOMINAL);
  wire [bgd_pkg::FREQ_W-1:0] seg10_lo = seg10_lo_of(NOMINAL);
  // clamped index of the captured frequency
  wire [4:0] fidx = freq_index(freq_r, seg_w, seg10_lo);

  // thermometer of live or peak power
  wire [bgd_pkg::SEG_N-1:0] live_bar = bar_of(pwr_steps(POWER));
  wire [bgd_pkg::SEG_N-1:0] peak_bar = bar_of(pwr_steps(peak_r));
  wire [bgd_pkg::SEG_N-1:0] freq_bar = bgd_pkg::SEG_N'(1) << fseg_r;
  wire [bgd_pkg::SEG_N-1:0] mid_bar = bgd_pkg::SEG_N'(1) << bgd_pkg::MID_SEG;

  // a cycle ends on its done pulse or when sonics stop, whichever comes first
  wire cycle_end = CYCLE_DONE || !SONICS_ON;

  always_comb begin
    state_nxt = state_r;
    peak_nxt = peak_r;
    unique case (state_r)
      bgd_pkg::BGD_IDLE, bgd_pkg::BGD_HOLD: begin
        if (SONICS_ON) begin
          state_nxt = bgd_pkg::BGD_LIVE;
          peak_nxt = POWER;
        end
      end
      bgd_pkg::BGD_LIVE: begin
        if (POWER > peak_r) peak_nxt = POWER;
        if (cycle_end) state_nxt = bgd_pkg::BGD_HOLD;
      end
      default: state_nxt = bgd_pkg::BGD_IDLE;
    endcase
  end

  // alarm events; either source sets the latch
  wire alarm_event = OVERLOAD || MEM_RESET;
  // set wins over a clear in the same cycle so a fresh event is never lost
  assign alarm_nxt = alarm_event ? 1'b1 : (ALARM_CLEAR ? 1'b0 : alarm_r);

  wire show_freq = (POST_SEL == bgd_pkg::POST_FREQ);
  wire in_hold = (state_r == bgd_pkg::BGD_HOLD);
  wire [bgd_pkg::SEG_N-1:0] post_bar = show_freq ? freq_bar : peak_bar;
  // dark phase shows nothing, lit phase only the middle segment
  wire [bgd_pkg::SEG_N-1:0] alarm_bar = blink ? mid_bar : '0;

  always_comb begin
    if (alarm_r) begin
      seg_nxt = alarm_bar;
    end else if (SONICS_ON) begin
      seg_nxt = live_bar;
    end else if (in_hold) begin
      seg_nxt = post_bar;
    end else begin
      seg_nxt = '0;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_r <= bgd_pkg::BGD_IDLE;
      peak_r <= '0;
      alarm_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      peak_r <= peak_nxt;
      alarm_r <= alarm_nxt;
    end
  end

  // frequency captured on the done pulse only, index one cycle later; the division sits
  // behind a register so it never lies on the path to the output flops
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      freq_r <= '0;
      fseg_r <= 5'h00;
    end else begin
      if (CYCLE_DONE) freq_r <= FREQ_STORED;
      fseg_r <= fidx;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      SEGMENTS <= '0;
      POWER_SYMBOL <= 1'b0;
    end else begin
      // outputs come straight from flops so the glass never sees decode glitches
      SEGMENTS <= seg_nxt;
      POWER_SYMBOL <= SONICS_ON;
    end
  end
endmodule : bgd_driver

// File: bgd_lcd_model.sv
// lcd glass model: counts lit segments and finds the highest lit one
`timescale 1ns/100ps
module bgd_lcd_model (
  input wire logic [19:0] seg,
  input wire logic sym,
  output int lit,
  output int top,
  output logic bolt
);
  // glass shows only what is driven
  always_comb begin
    lit = $countones(seg);
    top = -1;
    for (int i = 0; i < 20; i++)
      if (seg[i]) top = i;
    bolt = sym;
  end
endmodule : bgd_lcd_model

// File: bgd_driver_assertions.sv
// concurrent checks on the bar-graph driver ports
`timescale 1ns/100ps
module bgd_driver_assertions #(parameter int BLINK_HALF = 4) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic SONICS_ON,
  input wire logic [9:0] POWER,
  input wire logic CYCLE_DONE,
  input wire logic [1:0] NOMINAL,
  input wire logic POST_SEL,
  input wire logic OVERLOAD,
  input wire logic MEM_RESET,
  input wire logic ALARM_CLEAR,
  input wire logic [19:0] SEGMENTS,
  input wire logic POWER_SYMBOL
);
  logic alm_r;
  wire ev = OVERLOAD | MEM_RESET;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) alm_r <= 1'b0;
    else alm_r <= ev | (alm_r & ~ALARM_CLEAR);
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  sequence s_idle;
    !SONICS_ON && !CYCLE_DONE && !ev && !alm_r && $stable(POST_SEL) && $stable(NOMINAL);
  endsequence
  sequence s_end(logic m);
    CYCLE_DONE && POST_SEL == m && !SONICS_ON && !ev && !alm_r;
  endsequence
  property p_sym_on; SONICS_ON |=> POWER_SYMBOL; endproperty
  a_sym_on: assert property (p_sym_on) else $error("symbol off");
  property p_sym_off; !SONICS_ON |=> !POWER_SYMBOL; endproperty
  a_sym_off: assert property (p_sym_off) else $error("symbol on");
  property p_live; SONICS_ON && !CYCLE_DONE && !ev && !alm_r && !$past(alm_r)
    |=> SEGMENTS == 20'((21'h1 << ($past(POWER) / 10'd50)) - 21'h1); endproperty
  a_live: assert property (p_live) else $error("live bar");
  property p_hold; s_idle [*4] |=> $stable(SEGMENTS); endproperty
  a_hold: assert property (p_hold) else $error("post bar moved");
  property p_freq; s_end(1'b1) ##1 s_idle [*2] |=> $onehot(SEGMENTS); endproperty
  a_freq: assert property (p_freq) else $error("freq bar");
  property p_peak; s_end(1'b0) ##1 s_idle |=> (SEGMENTS & (SEGMENTS + 20'h1)) == 20'h0;
  endproperty
  a_peak: assert property (p_peak) else $error("peak bar");
  property p_alarm; alm_r && $past(alm_r) |-> (SEGMENTS & ~20'h00200) == 20'h0; endproperty
  a_alarm: assert property (p_alarm) else $error("alarm mask");
  // repetition of 3 assumes BLINK_HALF of 4
  property p_blink; alm_r && $past(alm_r, 2) && $changed(SEGMENTS[9])
    |=> (!alm_r || $stable(SEGMENTS[9])) [*3]; endproperty
  a_blink: assert property (p_blink) else $error("blink rate");
endmodule : bgd_driver_assertions
bind bgd_driver bgd_driver_assertions #(.BLINK_HALF(BLINK_HALF)) chk_u (.*);

// File: bgd_driver_tb.sv
// self-checking bench for the bar-graph driver
`timescale 1ns/100ps
module bgd_driver_tb;
  logic CLK = 0, NRST = 0, SONICS_ON = 0, CYCLE_DONE = 0, POST_SEL = 0, POWER_SYMBOL;
  logic OVERLOAD = 0, MEM_RESET = 0, ALARM_CLEAR = 0, bolt;
  logic [9:0] POWER = 0;
  logic [16:0] FREQ_STORED = 0;
  logic [1:0] NOMINAL = 0;
  logic [19:0] SEGMENTS;
  int mismatches = 0, samples_checked = 0, lit, top, pk, t;
  int unsigned rs = 39;
  int pv[$] = '{0, 49, 50, 999, 1000, 1023};
  int fv[10] = '{19975, 20024, 19974, 19475, 19000, 21000, 29960, 30100, 39950, 41000};
  bgd_driver #(.BLINK_HALF(4)) dut_u (.*);
  bgd_lcd_model lcd_u (.seg(SEGMENTS), .sym(POWER_SYMBOL), .lit(lit), .top(top), .bolt(bolt));
  initial forever #50 CLK = ~CLK;
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      mismatches++;
      $display("unexpected at %0t: saw %0h want %0h", $time, seen, want);
    end
  endtask : check
  function automatic int rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs % 1024;
  endfunction : rnd
  function automatic int fidx(int f, int nm);
    int w;
    w = nm == 1 ? 76 : nm == 3 ? 100 : 50;
    f = f - (nm == 1 ? 29960 : nm == 3 ? 39950 : 19975) + 10 * w;
    return f < 0 ? 0 : f / w > 19 ? 19 : f / w;
  endfunction : fidx
  task automatic step(int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask : step
  task automatic weld(int f, int k);
    int p, nm;
    nm = f < 25000 ? 0 : f < 35000 ? 1 : 3;
    pk = 0;
    SONICS_ON = 1;
    NOMINAL = nm[1:0];
    repeat (k) begin
      p = pv.size() ? pv.pop_front() : rnd();
      POWER = p[9:0];
      pk = p > pk ? p : pk;
      step(1);
      check(SEGMENTS, (1 << p / 50) - 1);
      check(lit * 2 + bolt, p / 50 * 2 + 1);
    end
    SONICS_ON = 0;
    CYCLE_DONE = 1;
    POWER = 0;
    FREQ_STORED = f[16:0];
    step(1);
    CYCLE_DONE = 0;
    step(2);
    check(bolt, 0);
    check(SEGMENTS, POST_SEL ? 1 << fidx(f, nm) : (1 << pk / 50) - 1);
    if (POST_SEL) check(top, fidx(f, nm));
  endtask : weld
  initial begin
    #3000000;
    mismatches++;
    complete_run();
  end
  initial begin
    repeat (20) @(posedge CLK);
    #1;
    NRST = 1;
    step(1);
    weld(20000, 9);
    POST_SEL = 1;
    foreach (fv[i]) weld(fv[i], 2);
    POST_SEL = 0;
    for (int m = 0; m < 2; m++) begin
      weld(20000, 2);
      OVERLOAD = m == 0;
      MEM_RESET = m == 1;
      step(1);
      OVERLOAD = 0;
      MEM_RESET = 0;
      t = 0;
      step(1);
      repeat (12) begin
        step(1);
        t += SEGMENTS[9];
        check(SEGMENTS & ~20'h00200, 0);
      end
      check(t > 0 && t < 12, 1);
      ALARM_CLEAR = 1;
      step(1);
      ALARM_CLEAR = 0;
    end
    weld(20000, 3);
    complete_run();
  end
endmodule : bgd_driver_tb
